//--- hw/aio_control.v
// What this block does
// [RULE_01] two states, running and stopped, command driven
// [RULE_02] running: sample and process inputs; the code rejects measurements during warm-up
// [RULE_03] stopped: no sampling, commands still accepted
// [RULE_04] run command: reset sequence, then completion message
// [RULE_05] ground switch holds last command, 1 open
// [RULE_06] pulse ignored while stopped
// [RULE_07] pulse to current state does nothing
// [RULE_08] battery on only while running
// [RULE_09] at most one excitation channel active
// [RULE_10] inverted excitation is negated programmed value
// [RULE_11] excitation accepted only -5 to +5 volts
// [RULE_12] filter cutoff programmable 10 to 1900 Hz
// [RULE_13] warm-up delay up to 65.535 seconds
// [RULE_14] warm-up at least 3 sampling periods
// [RULE_15] calibrate command runs self-calibration
// [RULE_16] reference-error read returns factory value
// [RULE_17] gain-16 coefficients readable on request
// [RULE_18] gain selectable unity or sixteen only
// [RULE_19] differential pairs 1-2, 3-4, 5-6, odd high
// [RULE_20] conversion result is 24 bits
// [RULE_21] paired terminal and sense measurement
// [RULE_22] power-up: stopped, battery off, open, no excitation
`timescale 1ns/1ps
`default_nettype none
`include "aio_map.vh"
module aio_control #(
  parameter [31:0] RSTSEQ_CYC = `AIO_RSTSEQ_CYC,
  parameter [31:0] MS_CYC = `AIO_MS_CYC,
  parameter [23:0] REF_ERR = 24'h000000,
  parameter [23:0] COEF16 = 24'h000000
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // host command
  input wire cmdValid,
  input wire [3:0] cmdCode,
  input wire [15:0] cmdArg,
  // converter side
  input wire convDone,
  input wire [23:0] convData,
  output reg convStart,
  output reg [2:0] convChanP,
  output reg [2:0] convChanN,
  output reg convSense,
  output reg calStart,
  input wire calDone,
  // sampling period tick from the converter clocking
  input wire samplePeriod,
  // host answer
  output reg ansValid,
  output reg [3:0] ansCode,
  output reg [23:0] ansData,
  // module outputs
  output reg running,
  output reg ground_switch_output,
  output reg switched_battery_output,
  output reg [2:0] excChannel,
  output reg signed [3:0] excVolts,
  output reg signed [3:0] inverted_excitation_output,
  output reg gain16,
  output reg [10:0] filterHz,
  output reg busy
);
  localparam [2:0] ST_STOP = 3'h0;
  localparam [2:0] ST_RSTSEQ = 3'h1;
  localparam [2:0] ST_WARM = 3'h2;
  localparam [2:0] ST_RUN = 3'h3;
  localparam [2:0] ST_CONV = 3'h4;
  localparam [2:0] ST_CAL = 3'h5;

  reg [2:0] state;
  reg [31:0] cnt;
  reg [31:0] msCnt;
  reg [15:0] warmMs;
  reg [15:0] warmLeft;
  reg [15:0] periods;
  reg pairPhase;
  reg pairReq;
  reg [2:0] resumeState;
  wire pulseSync;
  wire signed [3:0] argVolts;
  wire [2:0] argChan;
  wire [2:0] argChanN;
  wire argDiff;
  wire [2:0] argChanP;
  reg next_running;
  reg next_busy;

  assign argVolts = cmdArg[3:0];
  assign argChan = cmdArg[6:4];
  assign argDiff = cmdArg[7];
  // pairs 0-1, 2-3, 4-5: odd numbered (zero-based even) line is the high side
  assign argChanN = argDiff ? {argChan[2:1], 1'b1} : `AIO_CHAN_NONE; // [RULE_19]
  // a differential request always lands on the high line of its pair
  assign argChanP = argDiff ? {argChan[2:1], 1'b0} : argChan; // [RULE_19]

  aio_sync uSync (
    .mclk(mclk),
    .rst(rst),
    .din(samplePeriod),
    .dout(pulseSync)
  );
  reg pulseSyncD;
  wire periodTick;
  assign periodTick = pulseSync & ~pulseSyncD;

  // mode flags from the state; a calibration keeps the mode it interrupted
  always @* begin
    next_running = 1'b0;
    next_busy = 1'b0;
    case (state)
      ST_STOP: begin
        next_running = 1'b0;
      end
      ST_RSTSEQ: begin
        next_busy = 1'b1;
      end
      ST_WARM, ST_RUN: begin
        next_running = 1'b1;
      end
      ST_CONV: begin
        next_running = 1'b1;
        next_busy = 1'b1;
      end
      ST_CAL: begin
        next_running = (resumeState == ST_WARM) || (resumeState == ST_RUN); // [RULE_01]
        next_busy = 1'b1;
      end
      default: begin
        next_running = 1'b0;
        next_busy = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_STOP; // [RULE_22]
      running <= 1'b0;
      ground_switch_output <= 1'b1;
      switched_battery_output <= 1'b0;
      excChannel <= `AIO_CHAN_NONE;
      excVolts <= 4'sh0;
      inverted_excitation_output <= 4'sh0;
      gain16 <= 1'b0;
      filterHz <= `AIO_FILT_RST;
      warmMs <= 16'h0000;
      warmLeft <= 16'h0000;
      periods <= 16'h0000;
      cnt <= 32'h00000000;
      msCnt <= 32'h00000000;
      convStart <= 1'b0;
      convChanP <= 3'h0;
      convChanN <= `AIO_CHAN_NONE;
      convSense <= 1'b0;
      calStart <= 1'b0;
      ansValid <= 1'b0;
      ansCode <= `AIO_ANS_NONE;
      ansData <= 24'h000000;
      pairPhase <= 1'b0;
      pairReq <= 1'b0;
      resumeState <= ST_STOP;
      busy <= 1'b0;
      pulseSyncD <= 1'b0;
    end else begin
      pulseSyncD <= pulseSync;
      convStart <= 1'b0;
      calStart <= 1'b0;
      ansValid <= 1'b0;
      inverted_excitation_output <= -excVolts; // [RULE_10]
      running <= next_running; // [RULE_01]
      busy <= next_busy;
      // sampling ticks are counted even in a cycle taken by a command
      if ((state == ST_WARM) && periodTick && (periods != `AIO_WARM_MIN_PERIODS)) begin
        periods <= periods + 16'h1; // [RULE_14]
      end
      if (cmdValid) begin
        case (cmdCode)
          `AIO_CMD_STOP: begin
            state <= ST_STOP; // [RULE_01]
            running <= 1'b0; // [RULE_01]
            switched_battery_output <= 1'b0; // [RULE_08]
          end
          `AIO_CMD_RUN: begin
            state <= ST_RSTSEQ; // [RULE_04]
            running <= 1'b0; // [RULE_01]
            cnt <= 32'h00000000;
            switched_battery_output <= 1'b0; // [RULE_08]
          end
          `AIO_CMD_PULSE: begin
            // stopped discards; same state is a no-op
            if (running && (ground_switch_output != cmdArg[0])) begin // [RULE_06] [RULE_07]
              ground_switch_output <= cmdArg[0]; // [RULE_05]
            end
          end
          `AIO_CMD_BAT: begin
            switched_battery_output <= cmdArg[0] & running; // [RULE_08]
          end
          `AIO_CMD_EXC: begin
            if (cmdArg[8]) begin
              excChannel <= `AIO_CHAN_NONE;
              excVolts <= 4'sh0;
            end else if (argVolts >= `AIO_EXC_MIN && argVolts <= `AIO_EXC_MAX &&
                         argChan < 3'h6) begin // [RULE_11]
              excChannel <= argChan; // single register: one channel only [RULE_09]
              excVolts <= argVolts;
            end else begin
              ansValid <= 1'b1;
              ansCode <= `AIO_ANS_REJECT;
            end
          end
          `AIO_CMD_FILT: begin
            if (cmdArg[10:0] >= `AIO_FILT_MIN && cmdArg[10:0] <= `AIO_FILT_MAX) begin
              filterHz <= cmdArg[10:0]; // [RULE_12]
            end else begin
              ansValid <= 1'b1;
              ansCode <= `AIO_ANS_REJECT;
            end
          end
          `AIO_CMD_WARM: warmMs <= cmdArg; // [RULE_13]
          `AIO_CMD_GAIN: gain16 <= cmdArg[0]; // [RULE_18]
          `AIO_CMD_CAL: begin
            if (state != ST_CONV && state != ST_CAL) begin
              resumeState <= state;
              state <= ST_CAL;
              calStart <= 1'b1; // [RULE_15]
            end
          end
          `AIO_CMD_REFERR: begin
            ansValid <= 1'b1;
            ansCode <= `AIO_ANS_REFERR;
            ansData <= REF_ERR; // [RULE_16]
          end
          `AIO_CMD_COEF16: begin
            ansValid <= 1'b1;
            ansCode <= `AIO_ANS_COEF16;
            ansData <= COEF16; // [RULE_17]
          end
          `AIO_CMD_MEAS, `AIO_CMD_PAIR: begin
            if (state == ST_RUN) begin // [RULE_02] [RULE_03]
              state <= ST_CONV;
              convStart <= 1'b1;
              convChanP <= argChanP; // [RULE_19]
              convChanN <= argChanN;
              convSense <= cmdArg[9];
              pairReq <= (cmdCode == `AIO_CMD_PAIR);
              pairPhase <= 1'b0;
            end else begin
              ansValid <= 1'b1;
              ansCode <= `AIO_ANS_REJECT;
            end
          end
          default: begin
            ansValid <= 1'b1;
            ansCode <= `AIO_ANS_REJECT;
          end
        endcase
      end else begin
        case (state)
          ST_RSTSEQ: begin
            if (cnt >= RSTSEQ_CYC - 32'h1) begin
              state <= ST_WARM;
              warmLeft <= warmMs;
              periods <= 16'h0000;
              msCnt <= 32'h00000000;
              ansValid <= 1'b1;
              ansCode <= `AIO_ANS_RUNDONE; // [RULE_04]
            end else begin
              cnt <= cnt + 32'h1;
            end
          end
          ST_WARM: begin
            if (warmLeft != 16'h0000) begin
              if (msCnt >= MS_CYC - 32'h1) begin
                msCnt <= 32'h00000000;
                warmLeft <= warmLeft - 16'h1; // [RULE_13]
              end else begin
                msCnt <= msCnt + 32'h1;
              end
            end else if (periods == `AIO_WARM_MIN_PERIODS) begin // [RULE_14]
              state <= ST_RUN;
            end
          end
          ST_CONV: begin
            if (convDone) begin
              ansValid <= 1'b1;
              ansData <= convData; // [RULE_20]
              if (pairReq) begin
                ansCode <= pairPhase ? `AIO_ANS_PAIR_SENSE : `AIO_ANS_PAIR_TERM;
                if (!pairPhase) begin
                  pairPhase <= 1'b1;
                  convSense <= 1'b1; // [RULE_21]
                  convStart <= 1'b1;
                end else begin
                  state <= ST_RUN;
                end
              end else begin
                ansCode <= `AIO_ANS_SAMPLE; // [RULE_02]
                state <= ST_RUN;
              end
            end
          end
          ST_CAL: begin
            if (calDone) begin
              state <= resumeState;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/aio_map.vh
`ifndef AIO_MAP_VH
`define AIO_MAP_VH
// command codes
`define AIO_CMD_RUN 4'h1
`define AIO_CMD_STOP 4'h2
`define AIO_CMD_PULSE 4'h3
`define AIO_CMD_BAT 4'h4
`define AIO_CMD_EXC 4'h5
`define AIO_CMD_FILT 4'h6
`define AIO_CMD_WARM 4'h7
`define AIO_CMD_CAL 4'h8
`define AIO_CMD_REFERR 4'h9
`define AIO_CMD_COEF16 4'ha
`define AIO_CMD_GAIN 4'hb
`define AIO_CMD_MEAS 4'hc
`define AIO_CMD_PAIR 4'hd
// answer codes
`define AIO_ANS_NONE 4'h0
`define AIO_ANS_RUNDONE 4'h1
`define AIO_ANS_REFERR 4'h2
`define AIO_ANS_COEF16 4'h3
`define AIO_ANS_SAMPLE 4'h4
`define AIO_ANS_PAIR_TERM 4'h5
`define AIO_ANS_PAIR_SENSE 4'h6
`define AIO_ANS_REJECT 4'hf
// limits and reset values
`define AIO_EXC_MIN 4'shb
`define AIO_EXC_MAX 4'sh5
`define AIO_FILT_MIN 11'h00a
`define AIO_FILT_MAX 11'h76c
`define AIO_FILT_RST 11'h03c
`define AIO_WARM_MIN_PERIODS 16'h0003
`define AIO_CHAN_NONE 3'h7
// timing: reset sequence 20 us, 1 ms tick for warm-up
`define AIO_RSTSEQ_NS 20000
`define AIO_CLK_NS 10
`define AIO_RSTSEQ_CYC (`AIO_RSTSEQ_NS / `AIO_CLK_NS)
`define AIO_MS_NS 1000000
`define AIO_MS_CYC (`AIO_MS_NS / `AIO_CLK_NS)
`endif

//--- hw/aio_sync.v
`timescale 1ns/1ps
`default_nettype none
module aio_sync (
  // clock and reset
  input wire mclk,
  input wire rst,
  // level in and out
  input wire din,
  output reg dout
);
  reg meta;
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

//--- test/aio_control_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "aio_map.vh"
module aio_control_properties #(
  parameter [23:0] REF_ERR = 24'h000000
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // host side
  input wire cmdValid,
  input wire [3:0] cmdCode,
  input wire [15:0] cmdArg,
  input wire ansValid,
  input wire [3:0] ansCode,
  input wire [23:0] ansData,
  // module outputs
  input wire running,
  input wire ground_switch_output,
  input wire switched_battery_output,
  input wire [2:0] excChannel,
  input wire signed [3:0] excVolts,
  input wire signed [3:0] inverted_excitation_output,
  input wire [10:0] filterHz
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence runCmd;
    cmdValid && cmdCode == `AIO_CMD_RUN;
  endsequence
  sequence runDone;
    ansValid && ansCode == `AIO_ANS_RUNDONE;
  endsequence
  a_run_completes: assert property (runCmd |-> ##[1:12] runDone)
    else $error("run completion missing");
  a_stop_halts: assert property (cmdValid && cmdCode == `AIO_CMD_STOP |=> !running)
    else $error("still running after stop");
  a_pulse_ignored: assert property (cmdValid && cmdCode == `AIO_CMD_PULSE && !running
    |=> $stable(ground_switch_output))
    else $error("ground switch moved while stopped");
  a_pulse_applied: assert property (cmdValid && cmdCode == `AIO_CMD_PULSE && running
    |=> ground_switch_output == $past(cmdArg[0]))
    else $error("ground switch not set");
  a_battery_off_stopped: assert property (!running ##1 !running |-> !switched_battery_output)
    else $error("battery on while stopped");
  a_exc_negated: assert property (1'b1 |=> inverted_excitation_output == -$past(excVolts))
    else $error("inverted excitation wrong");
  a_exc_in_range: assert property (excVolts >= `AIO_EXC_MIN && excVolts <= `AIO_EXC_MAX)
    else $error("excitation out of range");
  a_one_channel: assert property (excChannel <= 3'h5 || excChannel == `AIO_CHAN_NONE)
    else $error("bad excitation channel");
  a_filter_range: assert property (filterHz >= `AIO_FILT_MIN && filterHz <= `AIO_FILT_MAX)
    else $error("filter cutoff out of range");
  a_ref_answer: assert property (cmdValid && cmdCode == `AIO_CMD_REFERR
    |=> ansValid && ansCode == `AIO_ANS_REFERR && ansData == REF_ERR)
    else $error("reference error answer wrong");
endmodule
bind aio_control aio_control_properties #(.REF_ERR(REF_ERR)) i_props (.mclk(mclk), .rst(rst),
  .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdArg(cmdArg), .ansValid(ansValid),
  .ansCode(ansCode), .ansData(ansData), .running(running),
  .ground_switch_output(ground_switch_output), .switched_battery_output(switched_battery_output),
  .excChannel(excChannel), .excVolts(excVolts),
  .inverted_excitation_output(inverted_excitation_output), .filterHz(filterHz));
`default_nettype wire

//--- test/aio_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module aio_conv_model (
  // clock and reset
  input wire mclk,
  input wire rst,
  // requests from the control block
  input wire convStart,
  input wire [2:0] convChanP,
  input wire convSense,
  input wire calStart,
  // converter answers
  output logic convDone,
  output logic [23:0] convData,
  output logic calDone,
  output logic samplePeriod
);
  int n;
  logic c;
  initial begin
    convDone = 0;
    calDone = 0;
    convData = 24'h000000;
    samplePeriod = 0;
  end
  // free-running sampling period, not tied to mclk phase
  always #203 samplePeriod = ~samplePeriod;
  // requests are taken at the edge, so a restart at the done edge is seen
  always @(posedge mclk) begin
    if (!rst && (convStart || calStart)) begin
      c = convStart;
      n = 1 + $urandom % 6;
      repeat (n) @(posedge mclk);
      #1;
      convData = c ? {convSense, 4'h0, convChanP, 16'h5a3c} : ~convData;
      convDone = c;
      calDone = !c;
      @(posedge mclk);
      #1;
      convDone = 0;
      calDone = 0;
      convData = ~convData;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "aio_map.vh"
module tb_top;
  localparam [23:0] RE = 24'h00a5c3;
  localparam [23:0] CF = 24'h013579;
  logic mclk = 0, rst = 1, cmdValid = 0;
  logic [3:0] cmdCode = 4'h0, v;
  logic [15:0] cmdArg = 16'h0000;
  logic [2:0] ch;
  wire convDone, calDone, samplePeriod, convStart, convSense, calStart, ansValid, running;
  wire gnd, bat, gain16, busy;
  wire [23:0] convData, ansData;
  wire [2:0] convChanP, convChanN, excChannel;
  wire [3:0] ansCode;
  wire signed [3:0] excVolts, invExc;
  wire [10:0] filterHz;
  int n_checks = 0, n_mismatch = 0, i, seed;
  always #5 mclk = ~mclk;
  aio_control #(.RSTSEQ_CYC(32'd10), .MS_CYC(32'd5), .REF_ERR(RE), .COEF16(CF)) i_dut (
    .mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdArg(cmdArg),
    .convDone(convDone), .convData(convData), .convStart(convStart), .convChanP(convChanP),
    .convChanN(convChanN), .convSense(convSense), .calStart(calStart), .calDone(calDone),
    .samplePeriod(samplePeriod), .ansValid(ansValid), .ansCode(ansCode), .ansData(ansData),
    .running(running), .ground_switch_output(gnd), .switched_battery_output(bat),
    .excChannel(excChannel), .excVolts(excVolts), .inverted_excitation_output(invExc),
    .gain16(gain16), .filterHz(filterHz), .busy(busy));
  aio_conv_model i_conv (.mclk(mclk), .rst(rst), .convStart(convStart), .convChanP(convChanP),
    .convSense(convSense), .calStart(calStart), .convDone(convDone), .convData(convData),
    .calDone(calDone), .samplePeriod(samplePeriod));
  function automatic logic [23:0] expD(input logic s, input logic [2:0] c);
    return {s, 4'h0, c, 16'h5a3c};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [15:0] a);
    @(posedge mclk);
    #1 cmdValid = 1;
    cmdCode = c;
    cmdArg = a;
    @(posedge mclk);
    #1 cmdValid = 0;
  endtask
  task automatic waitAns(input logic [3:0] c);
    int k;
    for (k = 0; k < 40 && ansValid !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk({ansValid, ansCode}, {1'b1, c});
    @(posedge mclk);
    #1;
  endtask
  initial begin
    #200000;
    n_mismatch++;
    results();
  end
  initial begin
    seed = $urandom(32'h53b3);
    repeat (12) @(posedge mclk);
    #1 rst = 0;
    chk({running, gnd, bat, excChannel}, 24'h17);
    cmd(`AIO_CMD_PULSE, 16'h0000);
    cmd(`AIO_CMD_BAT, 16'h0001);
    chk({gnd, bat}, 24'h2);
    cmd(`AIO_CMD_WARM, 16'h0002);
    cmd(`AIO_CMD_RUN, 16'h0000);
    waitAns(`AIO_ANS_RUNDONE);
    chk(running, 1);
    cmd(`AIO_CMD_MEAS, 16'h0000);
    waitAns(`AIO_ANS_REJECT);
    repeat (300) @(posedge mclk);
    for (i = 0; i < 2; i++) begin
      cmd(`AIO_CMD_PULSE, 16'(i));
      cmd(`AIO_CMD_PULSE, 16'(i));
      chk(gnd, 24'(i));
      cmd(`AIO_CMD_GAIN, 16'(1 - i));
      chk(gain16, 24'(1 - i));
    end
    cmd(`AIO_CMD_BAT, 16'h0001);
    chk(bat, 1);
    for (i = 0; i < 10; i++) begin
      v = (i == 8) ? 4'hb : (i == 9) ? 4'h5 : 4'($urandom % 11) - 4'h5;
      ch = 3'($urandom % 6);
      cmd(`AIO_CMD_EXC, {9'h000, ch, v});
      @(posedge mclk);
      #1;
      chk({excChannel, excVolts, invExc}, {ch, v, -v});
    end
    cmd(`AIO_CMD_EXC, 16'h0100);
    @(posedge mclk);
    #1;
    chk({excChannel, excVolts, invExc}, 24'h700);
    cmd(`AIO_CMD_EXC, 16'h0006);
    waitAns(`AIO_ANS_REJECT);
    cmd(`AIO_CMD_FILT, 16'h0009);
    waitAns(`AIO_ANS_REJECT);
    cmd(`AIO_CMD_FILT, 16'h076c);
    chk(filterHz, 24'h76c);
    cmd(`AIO_CMD_CAL, 16'h0000);
    for (i = 0; i < 3 && calStart !== 1'b1; i++) @(posedge mclk);
    chk(calStart, 1);
    @(posedge mclk);
    #1;
    chk({busy, running}, 24'h3);
    repeat (20) @(posedge mclk);
    #1;
    chk({busy, running}, 24'h1);
    cmd(`AIO_CMD_REFERR, 16'h0000);
    chk(ansData, RE);
    waitAns(`AIO_ANS_REFERR);
    cmd(`AIO_CMD_COEF16, 16'h0000);
    chk(ansData, CF);
    waitAns(`AIO_ANS_COEF16);
    ch = 3'($urandom % 6);
    cmd(`AIO_CMD_MEAS, {9'h000, ch, 4'h0});
    waitAns(`AIO_ANS_SAMPLE);
    chk(ansData, expD(0, ch));
    cmd(`AIO_CMD_MEAS, 16'h00b0);
    waitAns(`AIO_ANS_SAMPLE);
    chk({convChanP, convChanN}, 24'h13);
    cmd(`AIO_CMD_PAIR, 16'h0010);
    waitAns(`AIO_ANS_PAIR_TERM);
    chk(ansData, expD(0, 3'h1));
    waitAns(`AIO_ANS_PAIR_SENSE);
    chk(ansData, expD(1, 3'h1));
    cmd(`AIO_CMD_STOP, 16'h0000);
    chk({running, bat}, 24'h0);
    cmd(`AIO_CMD_PULSE, 16'h0000);
    chk(gnd, 1);
    cmd(`AIO_CMD_MEAS, 16'h0000);
    waitAns(`AIO_ANS_REJECT);
    cmd(4'hf, 16'h0000);
    waitAns(`AIO_ANS_REJECT);
    // reset again in mid-run with the battery on and the switch closed
    cmd(`AIO_CMD_RUN, 16'h0000);
    waitAns(`AIO_ANS_RUNDONE);
    cmd(`AIO_CMD_BAT, 16'h0001);
    cmd(`AIO_CMD_PULSE, 16'h0000);
    chk({gnd, bat}, 24'h1);
    rst = 1;
    repeat (2) @(posedge mclk);
    #1 rst = 0;
    chk({running, gnd, bat, excChannel}, 24'h17);
    results();
  end
endmodule
`default_nettype wire
